// ===== hw/dml_pkg.sv
/*
 diagnostic record logger: shared constants, register map, record layout.
 assumes a 32-bit APB slave with byte offsets on paddr[7:0].
*/
package dml_pkg;
	// capacity and ring indexing
	localparam logic [7:0] NREC = 8'hFA; // 250 records
	localparam logic [7:0] LAST_SLOT = 8'hF9;
	localparam logic [7:0] SUB_BASE = 8'h06; // subindex of slot 0
	////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_NEWEST = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_ACK = 8'h0C;
	localparam logic [7:0] A_SEL = 8'h10;
	localparam logic [7:0] A_CODE = 8'h14;
	localparam logic [7:0] A_FLTX = 8'h18;
	localparam logic [7:0] A_TSLO = 8'h1C;
	localparam logic [7:0] A_TSHI = 8'h20;
	localparam logic [7:0] A_PARM = 8'h24;
	localparam logic [7:0] A_IRQST = 8'h28;
	localparam logic [7:0] A_IRQMSK = 8'h2C;
	// reset values and bit positions
	localparam logic EMG_RST = 1'b1;
	localparam logic [7:0] SEL_RST = 8'h06;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_CNT_LSB = 8;
	localparam int IRQ_STORE = 0;
	localparam int IRQ_OVWR = 1;
	localparam int IRQ_ACKD = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;
	////////////////////////////////////////////////////////////////
	// record layout: code, flags, text id, timestamp, parameter
	localparam int REC_W = 160;
	localparam int R_CODE = 128;
	localparam int R_FLAG = 112;
	localparam int R_TEXT = 96;
	localparam int R_TS = 32;
	localparam int FL_CONF_BIT = 4;
	localparam logic [1:0] FL_INFO = 2'h0;
	localparam logic [1:0] FL_WARN = 2'h1;
	localparam logic [1:0] FL_ERR = 2'h2;
	// category and location digits of the text id
	localparam logic [3:0] CAT_SYS = 4'h0;
	localparam logic [3:0] CAT_INFO = 4'h1;
	localparam logic [3:0] CAT_WARN = 4'h4;
	localparam logic [3:0] CAT_ERR = 4'h8;
	localparam logic [3:0] LOC_SYS = 4'h0;
	// fixed text ids
	localparam logic [15:0] TID_NOERR = 16'h0001;
	localparam logic [15:0] TID_COMM = 16'h0002;
	localparam logic [7:0] TID_NET_HI = 8'h10;
	// diagnostic code of fixed entries, value arbitrary
	localparam logic [31:0] DCODE_FIXED = 32'h0000_0001;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SCAN = 2'b10
	} dml_state_t;
endpackage

// ===== hw/dml_textid.sv
/*
 composes one diagnostic record from the pending event sources.
 assumes event inputs are single-cycle pulses on the logger clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dml_textid import dml_pkg::*; (
	input wire logic evtValid,
	input wire logic [3:0] evtCategory,
	input wire logic [3:0] evtLocation,
	input wire logic [7:0] evtNumber,
	input wire logic [31:0] evtCode,
	input wire logic [31:0] evtParam,
	input wire logic netValid,
	input wire logic [3:0] netFrom,
	input wire logic [3:0] netTo,
	input wire logic commUp,
	input wire logic noErr,
	output logic recValid,
	output logic [15:0] recText,
	output logic [15:0] recFlags,
	output logic [31:0] recCode,
	output logic [31:0] recParam
);
	// category digit decides the record class
	function automatic logic [15:0] classify(input logic [3:0] cat);
		logic [15:0] f;
		f = 16'h0000;
		if (cat == CAT_ERR) begin // R12
			f[1:0] = FL_ERR;
		end else if (cat == CAT_WARN) begin
			f[1:0] = FL_WARN;
		end else begin
			f[1:0] = FL_INFO;
		end
		return f;
	endfunction

	// one source per cycle: event, network, link up, no error
	always_comb begin
		recValid = evtValid | netValid | commUp | noErr;
		recCode = DCODE_FIXED;
		recParam = 32'h0000_0000;
		if (evtValid) begin
			recText = {evtCategory, evtLocation, evtNumber}; // R11 R13
			recCode = evtCode;
			recParam = evtParam;
		end else if (netValid) begin
			recText = {TID_NET_HI, netFrom, netTo}; // R14
		end else if (commUp) begin
			recText = TID_COMM; // R14
		end else begin
			recText = TID_NOERR; // R14
		end
		recFlags = classify(recText[15:12]); // R4
	end
endmodule
`default_nettype wire

// ===== hw/dml_logger.sv
/*
 diagnostic record logger: ring of records, APB registers, acknowledge
 scan, emergency announcement and interrupt.
 assumes event inputs and the time base come from logic on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1 - every logged event, warning, error or state change stores one record; the code stores one per cycle and drops the other sources of that cycle
// R2 - no more than 250 records are held at once
// R3 - record is code, flags, text id, timestamp, then parameter
// R4 - flags word marks the record as info, warning or error
// R5 - unread flag stays up while stored records are unreported; the code drops it once the newest record's code is read
// R6 - acknowledge confirms only the newest unconfirmed record
// R7 - a register shows the subindex of the newest record
// R8 - while enabled, each new record is announced as an emergency
// R9 - announcing follows the last written enable value
// R10 - timestamp is the time base captured at the event
// R11 - text id is category, location and two-digit number
// R12 - category 0 system, 1 info, 4 warning, 8 error
// R13 - location 0 system to 6 general io, 7 reserved
// R14 - fixed ids for no error, link up and state transitions
// R15 - when full, the oldest record is overwritten
module dml_logger import dml_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic evtValid,
	input wire logic [3:0] evtCategory,
	input wire logic [3:0] evtLocation,
	input wire logic [7:0] evtNumber,
	input wire logic [31:0] evtCode,
	input wire logic [31:0] evtParam,
	input wire logic netValid,
	input wire logic [3:0] netFrom,
	input wire logic [3:0] netTo,
	input wire logic commUp,
	input wire logic noErr,
	input wire logic [63:0] dcTime,
	output logic unreadRecordFlag,
	output logic emgValid,
	output logic [15:0] emgTextId,
	output logic irq
);
	logic [1:0] rstPipe_ff;
	logic rstN;
	logic recValid;
	logic [15:0] recText, recFlags;
	logic [31:0] recCode, recParam;
	logic [REC_W-1:0] recMem [0:249];
	logic emgEn_ff, nxt_emgEn;
	logic [7:0] sel_ff, nxt_sel, newest_ff, nxt_newest;
	logic [7:0] count_ff, nxt_count, storeSlot, selSlot;
	logic [7:0] scanPtr_ff, nxt_scanPtr, scanLeft_ff, nxt_scanLeft;
	logic unread_ff, nxt_unread, pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr, emgValid_ff, nxt_emgValid, irq_ff;
	logic [31:0] prdata_ff, nxt_prdata, rdMux;
	logic [15:0] emgText_ff, nxt_emgText;
	logic [249:0] conf_ff, nxt_conf;
	logic [2:0] irqSt_ff, nxt_irqSt, irqMsk_ff, nxt_irqMsk, irqEvt;
	dml_state_t state_ff, nxt_state;
	logic apbDone, wr, selOk, mapped, ackReq;
	logic [REC_W-1:0] selRec;

	////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe_ff <= 2'h0;
		end else begin
			rstPipe_ff <= {rstPipe_ff[0], 1'b1};
		end
	end
	assign rstN = rstPipe_ff[1];

	// record composition from event sources
	dml_textid uText (
		.evtValid(evtValid),
		.evtCategory(evtCategory),
		.evtLocation(evtLocation),
		.evtNumber(evtNumber),
		.evtCode(evtCode),
		.evtParam(evtParam),
		.netValid(netValid),
		.netFrom(netFrom),
		.netTo(netTo),
		.commUp(commUp),
		.noErr(noErr),
		.recValid(recValid),
		.recText(recText),
		.recFlags(recFlags),
		.recCode(recCode),
		.recParam(recParam)
	);

	////////////////////////////////////////////////////////////////
	// ring slot for the next record, wrapping over the oldest
	always_comb begin
		if (count_ff == 8'h00 || newest_ff == LAST_SLOT) begin // R15
			storeSlot = 8'h00;
		end else begin
			storeSlot = newest_ff + 8'h01;
		end
	end

	// record memory, timestamp caught in the event cycle
	always_ff @(posedge clk_sys) begin
		if (recValid) begin // R1
			recMem[storeSlot] <= {recCode, recFlags, recText, dcTime,
				recParam}; // R3 R10
		end
	end

	////////////////////////////////////////////////////////////////
	// apb decode and read mux
	assign apbDone = psel & penable & pready_ff;
	assign wr = apbDone & pwrite;
	assign selSlot = sel_ff - SUB_BASE;
	assign selOk = (sel_ff >= SUB_BASE) && (selSlot < count_ff);
	assign selRec = selOk ? recMem[selSlot] : '0;
	assign ackReq = wr && paddr == A_ACK && pwdata[0];

	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h0000_0000;
		unique case (paddr)
			A_CTRL: rdMux[0] = emgEn_ff;
			A_NEWEST: rdMux[7:0] = newest_ff + SUB_BASE; // R7
			A_STATUS: begin
				rdMux[0] = unread_ff;
				rdMux[ST_BUSY_BIT] = state_ff == ST_SCAN;
				rdMux[ST_CNT_LSB +: 8] = count_ff;
			end
			A_ACK: rdMux = 32'h0000_0000;
			A_SEL: rdMux[7:0] = sel_ff;
			A_CODE: rdMux = selRec[R_CODE +: 32];
			A_FLTX: begin
				rdMux = {selRec[R_TEXT +: 16], selRec[R_FLAG +: 16]};
				rdMux[FL_CONF_BIT] = selOk & conf_ff[selSlot];
			end
			A_TSLO: rdMux = selRec[R_TS +: 32];
			A_TSHI: rdMux = selRec[R_TS+32 +: 32];
			A_PARM: rdMux = selRec[31:0];
			A_IRQST: rdMux[2:0] = irqSt_ff;
			A_IRQMSK: rdMux[2:0] = irqMsk_ff;
			default: mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// next state of registers, scan and outputs
	always_comb begin
		nxt_pready = psel & penable & ~pready_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (psel & penable & ~pready_ff) begin
			nxt_prdata = pwrite ? 32'h0000_0000 : rdMux;
			nxt_pslverr = ~mapped;
		end
		nxt_emgEn = emgEn_ff;
		nxt_sel = sel_ff;
		nxt_irqMsk = irqMsk_ff;
		if (wr && paddr == A_CTRL) begin
			nxt_emgEn = pwdata[0]; // R9
		end
		if (wr && paddr == A_SEL) begin
			nxt_sel = pwdata[7:0];
		end
		if (wr && paddr == A_IRQMSK) begin
			nxt_irqMsk = pwdata[2:0];
		end
		nxt_state = state_ff;
		nxt_scanPtr = scanPtr_ff;
		nxt_scanLeft = scanLeft_ff;
		nxt_conf = conf_ff;
		irqEvt = 3'h0;
		// walk back from the newest to the first unconfirmed record
		unique case (state_ff)
			ST_IDLE: begin
				if (ackReq && count_ff != 8'h00) begin // R6
					nxt_state = ST_SCAN;
					nxt_scanPtr = newest_ff;
					nxt_scanLeft = count_ff;
				end
			end
			ST_SCAN: begin
				if (!conf_ff[scanPtr_ff]) begin
					nxt_conf[scanPtr_ff] = 1'b1; // R6
					irqEvt[IRQ_ACKD] = 1'b1;
					nxt_state = ST_IDLE;
				end else if (scanLeft_ff == 8'h01) begin
					nxt_state = ST_IDLE; // nothing left to confirm
				end else begin
					nxt_scanLeft = scanLeft_ff - 8'h01;
					nxt_scanPtr = (scanPtr_ff == 8'h00) ? LAST_SLOT :
						scanPtr_ff - 8'h01;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_newest = newest_ff;
		nxt_count = count_ff;
		nxt_unread = unread_ff;
		// reading the newest code reports it; a store wins
		if (apbDone && !pwrite && paddr == A_CODE && selOk &&
			selSlot == newest_ff) begin
			nxt_unread = 1'b0;
		end
		nxt_emgValid = 1'b0;
		nxt_emgText = emgText_ff;
		if (recValid) begin
			nxt_newest = storeSlot; // R1
			nxt_conf[storeSlot] = 1'b0;
			nxt_unread = 1'b1; // R5
			irqEvt[IRQ_STORE] = 1'b1;
			if (count_ff == NREC) begin
				irqEvt[IRQ_OVWR] = 1'b1; // R15
			end else begin
				nxt_count = count_ff + 8'h01; // R2
			end
			if (emgEn_ff) begin
				nxt_emgValid = 1'b1; // R8
				nxt_emgText = recText;
			end
		end
		// sticky status, write one clears, events win
		nxt_irqSt = irqSt_ff;
		if (wr && paddr == A_IRQST) begin
			nxt_irqSt = irqSt_ff & ~pwdata[2:0];
		end
		nxt_irqSt = nxt_irqSt | irqEvt;
	end

	// registers only
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			emgEn_ff <= EMG_RST;
			sel_ff <= SEL_RST;
			newest_ff <= 8'h00;
			count_ff <= 8'h00;
			scanPtr_ff <= 8'h00;
			scanLeft_ff <= 8'h00;
			unread_ff <= 1'b0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			emgValid_ff <= 1'b0;
			emgText_ff <= 16'h0000;
			conf_ff <= '0;
			irqSt_ff <= IRQ_RST;
			irqMsk_ff <= IRQ_RST;
			irq_ff <= 1'b0;
			state_ff <= ST_IDLE;
		end else begin
			emgEn_ff <= nxt_emgEn;
			sel_ff <= nxt_sel;
			newest_ff <= nxt_newest;
			count_ff <= nxt_count;
			scanPtr_ff <= nxt_scanPtr;
			scanLeft_ff <= nxt_scanLeft;
			unread_ff <= nxt_unread;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
			emgValid_ff <= nxt_emgValid;
			emgText_ff <= nxt_emgText;
			conf_ff <= nxt_conf;
			irqSt_ff <= nxt_irqSt;
			irqMsk_ff <= nxt_irqMsk;
			irq_ff <= |(nxt_irqSt & nxt_irqMsk);
			state_ff <= nxt_state;
		end
	end

	// outputs straight from flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign unreadRecordFlag = unread_ff;
	assign emgValid = emgValid_ff;
	assign emgTextId = emgText_ff;
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////
	// checks on the logger behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstN);

	chk_count_limit: assert property (count_ff <= NREC) // R2
		else $error("record count above capacity");
	chk_store_newest: assert property (recValid |=> // R1
		newest_ff == $past(storeSlot) && !conf_ff[newest_ff])
		else $error("stored record not newest");
	chk_unread_set: assert property (recValid |=> unread_ff) // R5
		else $error("unread flag missing after store");
	chk_emg_announce: assert property (recValid && emgEn_ff |=> // R8
		emgValid_ff && emgTextId == $past(recText) ##1
		(!emgValid_ff || $past(recValid)))
		else $error("emergency not announced once");
	chk_emg_silent: assert property (recValid && !emgEn_ff |=> // R9
		!emgValid_ff)
		else $error("emergency sent while disabled");
	chk_ring_wrap: assert property (recValid && count_ff == NREC && // R15
		newest_ff == LAST_SLOT |=> newest_ff == 8'h00 &&
		count_ff == NREC)
		else $error("full ring did not overwrite oldest");
	chk_scan_bound: assert property ($rose(state_ff == ST_SCAN) |-> // R6
		##[1:250] state_ff == ST_IDLE)
		else $error("acknowledge scan did not finish");
	chk_ack_confirm: assert property (state_ff == ST_SCAN && // R6
		!conf_ff[scanPtr_ff] && !recValid |=>
		conf_ff[$past(scanPtr_ff)] && irqSt_ff[IRQ_ACKD])
		else $error("acknowledged record not confirmed");
	chk_class_err: assert property (recValid && // R4 R12
		recText[15:12] == CAT_ERR |-> recFlags[1:0] == FL_ERR)
		else $error("error category not flagged error");
	chk_net_textid: assert property (netValid && !evtValid |-> // R14
		recText == {TID_NET_HI, netFrom, netTo})
		else $error("state change text id wrong");
	chk_apb_answer: assert property (psel && penable && !pready_ff |=>
		pready_ff ##1 !pready_ff)
		else $error("apb answer not one cycle");
	chk_irq_level: assert property (irq_ff == |(irqSt_ff & irqMsk_ff))
		else $error("interrupt level wrong");

	cov_store: cover property (recValid && emgEn_ff);
	cov_wrap: cover property (recValid && count_ff == NREC);
	cov_ack: cover property (state_ff == ST_SCAN && !conf_ff[scanPtr_ff]);
	cov_unread_clr: cover property (unread_ff ##1 !unread_ff);
endmodule
`default_nettype wire

// ===== bench/dml_apb_master.sv
/*
 apb master model standing in for the fieldbus master reading records.
 assumes one clock shared with the logger, bus idle between transfers.
*/
`timescale 1ns/100ps
`default_nettype none
module dml_apb_master (
	input wire logic clk_sys,
	input wire logic pready,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// idle bus from time zero
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// setup, access held until pready sampled high, then release
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data is not held
	endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
/*
 self-checking bench of the diagnostic record logger.
 assumes the apb master model and the logger on one 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb import dml_pkg::*;;
	logic clk_sys = 1'b0;
	logic rst_b, psel, penable, pwrite, pready, pslverr, emgEn;
	logic [7:0] paddr, evtNumber;
	logic [31:0] pwdata, prdata, rd, lCode, lParam, evtCode, evtParam;
	logic evtValid, netValid, commUp, noErr;
	logic unreadRecordFlag, emgValid, irq;
	logic [3:0] evtCategory, evtLocation, netFrom, netTo;
	logic [63:0] dcTime, lTs;
	logic [15:0] emgTextId, lT;
	logic [1:0] lCls;
	logic [32:0] msk;
	logic [32:0] expQ[$];
	logic [32:0] mskQ[$];
	logic [15:0] emgQ[$];
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	int nEv = 0;
	int nw;
	localparam logic [15:0] CATS = 16'h8410;
	localparam logic [39:0] NETS = 40'h12_21_24_42_48;

	dml_logger dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .evtValid, .evtCategory,
		.evtLocation, .evtNumber, .evtCode, .evtParam, .netValid, .netFrom,
		.netTo, .commUp, .noErr, .dcTime, .unreadRecordFlag, .emgValid,
		.emgTextId, .irq);
	dml_apb_master u_m (.clk_sys, .pready, .prdata, .psel, .penable,
		.pwrite, .paddr, .pwdata);

	////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic stop_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// oldest note against each finished transfer or announcement
	always @(posedge clk_sys) begin
		if ((psel & penable & pready) === 1'b1) begin
			msk = mskQ.pop_front();
			chk("apb", expQ.pop_front() & msk, {pslverr, prdata} & msk);
		end
		if (emgValid === 1'b1)
			chk("emgTextId", emgQ.size() > 0 ? {17'h0, emgQ.pop_front()}
				: 33'h1_0000_0000, {17'h0, emgTextId});
	end

	////////////////////////////////////////////////////////////////
	// bus and event drivers, each noting what it expects
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		logic [32:0] e, logic [32:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		u_m.xfer(w, a, d, rd);
	endtask

	task automatic rdc(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
	endtask

	task automatic ev(int k, logic [3:0] c, logic [3:0] l, logic [7:0] n);
		lT = k == 0 ? {c, l, n} : k == 1 ? {8'h10, c, l}
			: k == 2 ? TID_COMM : TID_NOERR;
		lCls = c == CAT_ERR ? FL_ERR : c == CAT_WARN ? FL_WARN : FL_INFO;
		lCode = $urandom;
		lParam = $urandom;
		lTs = {$urandom, $urandom};
		@(posedge clk_sys);
		{evtValid, netValid, commUp, noErr} <= 4'b1000 >> k;
		{evtCategory, evtLocation, evtNumber} <= {c, l, n};
		{netFrom, netTo} <= {c, l};
		{evtCode, evtParam, dcTime} <= {lCode, lParam, lTs};
		if (emgEn)
			emgQ.push_back(lT);
		@(posedge clk_sys);
		{evtValid, netValid, commUp, noErr} <= 4'h0;
		nEv++;
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_b = 1'b0;
		emgEn = 1'b1;
		{evtValid, netValid, commUp, noErr} = 4'h0;
		{evtCategory, evtLocation, evtNumber, netFrom, netTo} = '0;
		{evtCode, evtParam, dcTime} = '0;
		void'($urandom(61502));
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdc(A_CTRL, 32'h1, 32'h1);
		rdc(A_NEWEST, 32'h6, 32'hFF);
		rdc(A_STATUS, 32'h0, 32'hFF01);
		rdc(A_IRQMSK, 32'h0, 32'h7);
		apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000, '1);
		wr(A_IRQMSK, 32'h7);
		// every category and location, full record read back
		for (int i = 0; i < 7; i++) begin
			ev(0, CATS[4 * (i % 4) +: 4], 4'(i), 8'($urandom));
			@(negedge clk_sys);
			chk("unreadRecordFlag", 1, unreadRecordFlag);
			nw = SUB_BASE + nEv - 1;
			wr(A_SEL, 32'(nw));
			rdc(A_NEWEST, 32'(nw), 32'hFF);
			rdc(A_STATUS, {16'h0, 8'(nEv), 8'h1}, 32'hFF01);
			rdc(A_FLTX, {lT, 14'h0, lCls}, 32'hFFFF_0013);
			rdc(A_TSLO, lTs[31:0], '1);
			rdc(A_TSHI, lTs[63:32], '1);
			rdc(A_PARM, lParam, '1);
			rdc(A_CODE, lCode, '1);
			rdc(A_STATUS, 32'h0, 32'h1);
			@(negedge clk_sys);
			chk("unreadRecordFlag", 0, unreadRecordFlag);
		end
		// fixed identifiers of transitions, link up and no error
		for (int i = 0; i < 5; i++)
			ev(1, NETS[8 * i + 4 +: 4], NETS[8 * i +: 4], 8'h0);
		ev(2, 4'h0, 4'h0, 8'h0);
		ev(3, 4'h0, 4'h0, 8'h0);
		// announcing off, then on again
		wr(A_CTRL, 32'h0);
		emgEn = 1'b0;
		ev(0, CAT_ERR, 4'h4, 8'h13);
		wr(A_CTRL, 32'h1);
		emgEn = 1'b1;
		ev(0, CAT_INFO, 4'h1, 8'h00);
		// two acks confirm newest then the one before
		nw = SUB_BASE + nEv - 1;
		for (int j = 0; j < 2; j++) begin
			wr(A_ACK, 32'h1);
			do begin
				rdc(A_STATUS, {16'h0, 8'(nEv), 8'h1}, 32'hFF01);
			end while (rd[1] !== 1'b0);
			wr(A_SEL, 32'(nw - j));
			rdc(A_FLTX, 32'h10, 32'h10);
		end
		wr(A_SEL, 32'(nw - 2));
		rdc(A_FLTX, 32'h0, 32'h10);
		// interrupt status, clear and mask
		rdc(A_IRQST, 32'h5, 32'h7);
		@(negedge clk_sys);
		chk("irq", 1, irq);
		wr(A_IRQST, 32'h7);
		rdc(A_IRQST, 32'h0, 32'h7);
		wr(A_IRQMSK, 32'h2);
		ev(0, CAT_WARN, 4'h5, 8'h01);
		@(negedge clk_sys);
		chk("irq", 0, irq);
		// fill past capacity
		while (nEv < 252)
			ev(0, CAT_WARN, 4'h3, 8'($urandom));
		rdc(A_STATUS, {16'h0, NREC, 8'h0}, 32'hFF00);
		rdc(A_NEWEST, 32'(SUB_BASE + (nEv - 1) % NREC), 32'hFF);
		rdc(A_IRQST, 32'h2, 32'h2);
		@(negedge clk_sys);
		chk("irq", 1, irq);
		chk("emgQ", 33'h0, 33'(emgQ.size()));
		chk("expQ", 33'h0, 33'(expQ.size()));
		stop_test();
	end
endmodule
`default_nettype wire
